// ===== inc/rcp_defs.svh
`ifndef RCP_DEFS_SVH
`define RCP_DEFS_SVH
`define CH_NL 8'h0A
`define CH_SP 8'h20
`define CH_COLON 8'h3A
`define CH_SEMI 8'h3B
`define CH_STAR 8'h2A
`define CH_QUERY 8'h3F
`define CH_POINT 8'h2E
`define CH_PLUS 8'h2B
`define CH_MINUS 8'h2D
`define CH_E 8'h45
`define CH_R 8'h52
`define CRD_MAX 4'hC
`define KEY_ESCAPE 4'hF
`define LOW_RANGE_MAX 16'h0096
`define NODE_VOLT_AC 4'h7
`define NODE_RANGE 4'h9
`define TOK_ON 96'h4F4E
`define TOK_OFF 96'h4F4646
`define TOK_HIGH 96'h48494748
`define ESR_QYE 2
`define ESR_EXE 4
`define ESR_CME 5
`define STB_QUES 3
`define STB_MAV 4
`define STB_ESB 5
`define STB_RQS 6
`endif

// ===== inc/rcp_pkg.sv
package rcp_pkg;
  typedef enum {P_START, P_HDR, P_COMMON, P_DATA, P_SKIP, P_FLUSH_RNG, P_FLUSH_AC}
    parse_state_type;
  typedef enum logic [2:0] {D_NONE, D_NR1, D_NR2, D_NR3, D_BOOL, D_WORD, D_BAD}
    data_kind_type;
endpackage

// ===== hdl/remote_command_parser.sv
// Functional notes
// - SRQ output high whenever an enabled service request condition exists.
// - Serial poll request returns the current status byte.
// - Reset leaves the unit in local state; keys and bus both work.
// - In remote only the escape key acts, and it returns to local.
// - Remote state shows an R character at the display corner.
// - New command during an unread response discards it, flags query error.
// - All link bytes are ASCII characters.
// - Numbers parse as integer, decimal, or decimal with exponent.
// - Boolean values are only the words ON and OFF.
// - Character responses stop at twelve characters; strings are unlimited.
// - Header matching is case insensitive.
// - Headers match only exact short or exact long forms.
// - A leading asterisk marks a common command or query.
// - Colons separate headers; at least one space precedes data.
// - Semicolons separate message units.
// - A message ends on EOI, newline, or newline with EOI.
// - Responses end newline plus EOI on GPIB, newline alone on serial.
// - First unit resolves from root, later units from previous unit level.
// - A leading colon in a unit resets the path to root.
// - Coupled commands wait for the terminator; others run in order.
// - Lone out-of-range coupled value errors; grouped with enabler it passes.
`include "rcp_defs.svh"
module remote_command_parser (
  // Clock and reset
  input wire logic clk_in,
  input wire logic nrst_in,
  // Received byte stream
  input wire logic rx_valid_in,
  input wire logic [7:0] rx_byte_in,
  input wire logic rx_eoi_in,
  output logic rx_ready_out,
  // Executed units
  output logic exec_valid_out,
  output logic exec_common_out,
  output logic [23:0] exec_code_out,
  output logic [3:0] exec_node_out,
  output logic exec_query_out,
  output rcp_pkg::data_kind_type exec_kind_out,
  output logic [31:0] exec_mant_out,
  output logic [3:0] exec_frac_out,
  output logic [7:0] exec_exp_out,
  output logic exec_neg_out,
  output logic exec_exp_neg_out,
  output logic exec_bool_out,
  output logic cmd_error_out,
  output logic range_error_out,
  // Response stream
  input wire logic resp_valid_in,
  input wire logic [7:0] resp_byte_in,
  input wire logic resp_last_in,
  input wire logic resp_char_type_in,
  output logic resp_ready_out,
  input wire logic serial_mode_in,
  output logic tx_valid_out,
  output logic [7:0] tx_byte_out,
  output logic tx_eoi_out,
  input wire logic tx_ready_in,
  output logic query_error_out,
  // Status and service request
  input wire logic [7:0] ese_in,
  input wire logic [7:0] sre_in,
  input wire logic ques_in,
  input wire logic esr_clear_in,
  input wire logic poll_req_in,
  output logic [7:0] esr_out,
  output logic srq_out,
  output logic poll_valid_out,
  output logic [7:0] poll_byte_out,
  // Panel and remote state
  input wire logic go_remote_in,
  input wire logic go_local_in,
  input wire logic key_press_in,
  input wire logic [3:0] key_code_in,
  output logic key_valid_out,
  output logic [3:0] key_code_out,
  output logic remote_out,
  output logic [7:0] display_char_out
);
  import rcp_pkg::*;

  parse_state_type pst;
  data_kind_type kind, kind_now, pa_kind;
  logic [95:0] tok;
  logic [3:0] tok_len, node, base, leaf, leaf_now, hdr_match;
  logic [3:0] frac, pa_frac, resp_cnt;
  logic [31:0] mant, pa_mant;
  logic [15:0] ip, pa_int;
  logic [7:0] expo, pa_exp, c, u, esr_set, stb_sum;
  logic [23:0] ccode;
  logic query, common, neg, eneg, pa_neg, pa_eneg, pend_ac, pend_rng, pend_high;
  logic range_high, fake_term, take, take_rx, is_digit, is_alpha, unit_end, is_end;
  logic resp_busy, resp_drop, nl_pend, resp_accept, mav, esb, srq_cond;
  logic press_s1, press_s2, press_s3, next_remote, key_edge;
  logic [3:0] code_s1, code_s2;

  function automatic logic [123:0] node_entry(input logic [3:0] i);
    logic [123:0] e;
    e = '0;
    case (i)
      4'h1: e = {4'h0, 4'h6, 4'h4, 80'("OUTPUT"), 32'("OUTP")};
      4'h2: e = {4'h0, 4'h7, 4'h4, 80'("VOLTAGE"), 32'("VOLT")};
      4'h3: e = {4'h0, 4'h9, 4'h4, 80'("FREQUENCY"), 32'("FREQ")};
      4'h4: e = {4'h1, 4'hA, 4'h4, 80'("PROTECTION"), 32'("PROT")};
      4'h5: e = {4'h1, 4'h5, 4'h4, 80'("STATE"), 32'("STAT")};
      4'h6: e = {4'h4, 4'h5, 4'h3, 80'("CLEAR"), 32'("CLE")};
      4'h7: e = {4'h2, 4'h2, 4'h2, 80'("AC"), 32'("AC")};
      4'h8: e = {4'h2, 4'h2, 4'h2, 80'("DC"), 32'("DC")};
      4'h9: e = {4'h2, 4'h5, 4'h4, 80'("RANGE"), 32'("RANG")};
      default: e = '0;
    endcase
    return e;
  endfunction

  // A token that is neither the exact short nor exact long form never matches.
  function automatic logic [3:0] node_match(input logic [3:0] parent, input logic [95:0] t,
                                            input logic [3:0] n);
    logic [123:0] e;
    logic [3:0] r;
    r = 4'h0;
    for (int i = 1; i < 10; i++) begin
      e = node_entry(4'(i));
      if (e[123:120] == parent && ((n == e[119:116] && t == {16'h0, e[111:32]}) ||
          (n == e[115:112] && t == {64'h0, e[31:0]}))) begin
        r = 4'(i);
      end
    end
    return r;
  endfunction

  function automatic logic [31:0] mul10_add(input logic [31:0] v, input logic [7:0] ch);
    return (v << 3) + (v << 1) + {28'h0, ch[3:0]};
  endfunction

  always_comb begin
    c = fake_term ? `CH_NL : rx_byte_in;
    take_rx = rx_valid_in && rx_ready_out;
    take = fake_term || take_rx;
    u = (c >= 8'h61 && c <= 8'h7A) ? (c - 8'h20) : c;
    is_digit = (c >= 8'h30 && c <= 8'h39);
    is_alpha = (u >= 8'h41 && u <= 8'h5A);
    is_end = take && c == `CH_NL;
    unit_end = take && (c == `CH_SEMI || c == `CH_NL) && pst != P_START &&
               pst != P_FLUSH_RNG && pst != P_FLUSH_AC;
    hdr_match = node_match(node, tok, tok_len);
    leaf_now = (pst == P_HDR) ? hdr_match : leaf;
    kind_now = (pst != P_DATA) ? D_NONE :
               (kind == D_WORD && (tok == `TOK_ON || tok == `TOK_OFF)) ? D_BOOL : kind;
  end

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      pst <= P_START;
      rx_ready_out <= 1'b1;
      fake_term <= 1'b0;
      tok <= '0;
      tok_len <= 4'h0;
      node <= 4'h0;
      base <= 4'h0;
      leaf <= 4'h0;
      query <= 1'b0;
      common <= 1'b0;
      ccode <= 24'h0;
      kind <= D_NONE;
      mant <= 32'h0;
      ip <= 16'h0;
      frac <= 4'h0;
      expo <= 8'h0;
      neg <= 1'b0;
      eneg <= 1'b0;
      pend_ac <= 1'b0;
      pend_rng <= 1'b0;
      pend_high <= 1'b0;
      range_high <= 1'b0;
      pa_kind <= D_NONE;
      pa_mant <= 32'h0;
      pa_int <= 16'h0;
      pa_frac <= 4'h0;
      pa_exp <= 8'h0;
      pa_neg <= 1'b0;
      pa_eneg <= 1'b0;
      exec_valid_out <= 1'b0;
      exec_common_out <= 1'b0;
      exec_code_out <= 24'h0;
      exec_node_out <= 4'h0;
      exec_query_out <= 1'b0;
      exec_kind_out <= D_NONE;
      exec_mant_out <= 32'h0;
      exec_frac_out <= 4'h0;
      exec_exp_out <= 8'h0;
      exec_neg_out <= 1'b0;
      exec_exp_neg_out <= 1'b0;
      exec_bool_out <= 1'b0;
      cmd_error_out <= 1'b0;
      range_error_out <= 1'b0;
    end else begin
      exec_valid_out <= 1'b0;
      cmd_error_out <= 1'b0;
      range_error_out <= 1'b0;
      if (take) begin
        fake_term <= 1'b0;
        if (take_rx && rx_eoi_in && c != `CH_NL) begin
          // EOI on a data byte: the byte is parsed now, the end is replayed next cycle.
          fake_term <= 1'b1;
          rx_ready_out <= 1'b0;
        end else if (fake_term) begin
          rx_ready_out <= 1'b1;
        end
      end
      case (pst)
        P_START: if (take) begin
          if (c == `CH_COLON) begin
            node <= 4'h0;
            pst <= P_HDR;
          end else if (c == `CH_STAR) begin
            pst <= P_COMMON;
          end else if (is_alpha || is_digit) begin
            node <= base;
            tok <= {tok[87:0], u};
            tok_len <= 4'h1;
            pst <= P_HDR;
          end else if (c != `CH_SP && c != `CH_SEMI && c != `CH_NL) begin
            cmd_error_out <= 1'b1;
            pst <= P_SKIP;
          end
        end
        P_HDR, P_COMMON: if (take) begin
          if (is_alpha || is_digit) begin
            tok <= {tok[87:0], u};
            tok_len <= (tok_len == 4'hF) ? 4'hF : tok_len + 4'h1;
          end else if (c == `CH_QUERY) begin
            query <= 1'b1;
          end else if (c == `CH_COLON && pst == P_HDR) begin
            tok <= '0;
            tok_len <= 4'h0;
            node <= hdr_match;
            if (hdr_match == 4'h0) begin
              cmd_error_out <= 1'b1;
              pst <= P_SKIP;
            end
          end else if (c == `CH_SP) begin
            tok <= '0;
            tok_len <= 4'h0;
            kind <= D_NONE;
            mant <= 32'h0;
            ip <= 16'h0;
            frac <= 4'h0;
            expo <= 8'h0;
            neg <= 1'b0;
            eneg <= 1'b0;
            common <= (pst == P_COMMON);
            ccode <= tok[23:0];
            leaf <= hdr_match;
            pst <= P_DATA;
            if (pst == P_HDR && hdr_match == 4'h0) begin
              cmd_error_out <= 1'b1;
              pst <= P_SKIP;
            end
          end else if (c != `CH_SEMI && c != `CH_NL) begin
            cmd_error_out <= 1'b1;
            pst <= P_SKIP;
          end
        end
        P_DATA: if (take) begin
          if (is_digit) begin
            if (kind == D_NONE || kind == D_NR1) begin
              kind <= D_NR1;
              mant <= mul10_add(mant, c);
              ip <= 16'(mul10_add({16'h0, ip}, c));
            end else if (kind == D_NR2) begin
              mant <= mul10_add(mant, c);
              frac <= frac + 4'h1;
            end else if (kind == D_NR3) begin
              expo <= 8'(mul10_add({24'h0, expo}, c));
            end else begin
              kind <= D_BAD;
            end
          end else if (c == `CH_POINT) begin
            kind <= (kind == D_NONE || kind == D_NR1) ? D_NR2 : D_BAD;
          end else if (u == `CH_E && (kind == D_NR1 || kind == D_NR2)) begin
            kind <= D_NR3;
          end else if (is_alpha) begin
            kind <= (kind == D_NONE || kind == D_WORD) ? D_WORD : D_BAD;
            tok <= {tok[87:0], u};
          end else if (c == `CH_PLUS || c == `CH_MINUS) begin
            if (kind == D_NONE) begin
              neg <= (c == `CH_MINUS);
            end else if (kind == D_NR3 && expo == 8'h0) begin
              eneg <= (c == `CH_MINUS);
            end else begin
              kind <= D_BAD;
            end
          end else if (c != `CH_SP && c != `CH_SEMI && c != `CH_NL) begin
            kind <= D_BAD;
          end
        end
        P_SKIP: begin
        end
        P_FLUSH_RNG: begin
          if (pend_rng) begin
            pend_rng <= 1'b0;
            range_high <= pend_high;
            exec_valid_out <= 1'b1;
            exec_common_out <= 1'b0;
            exec_node_out <= `NODE_RANGE;
            exec_query_out <= 1'b0;
            exec_kind_out <= D_WORD;
            exec_bool_out <= pend_high;
          end
          pst <= P_FLUSH_AC;
        end
        P_FLUSH_AC: begin
          if (pend_ac) begin
            pend_ac <= 1'b0;
            if (!range_high && pa_int > `LOW_RANGE_MAX) begin
              range_error_out <= 1'b1;
            end else begin
              exec_valid_out <= 1'b1;
              exec_common_out <= 1'b0;
              exec_node_out <= `NODE_VOLT_AC;
              exec_query_out <= 1'b0;
              exec_kind_out <= pa_kind;
              exec_mant_out <= pa_mant;
              exec_frac_out <= pa_frac;
              exec_exp_out <= pa_exp;
              exec_neg_out <= pa_neg;
              exec_exp_neg_out <= pa_eneg;
              exec_bool_out <= 1'b0;
            end
          end
          pst <= P_START;
          rx_ready_out <= 1'b1;
        end
        default: pst <= P_START;
      endcase
      if (unit_end) begin
        pst <= P_START;
        tok <= '0;
        tok_len <= 4'h0;
        query <= 1'b0;
        common <= 1'b0;
        if (pst == P_COMMON || common) begin
          exec_valid_out <= 1'b1;
          exec_common_out <= 1'b1;
          exec_code_out <= (pst == P_COMMON) ? tok[23:0] : ccode;
          exec_query_out <= query;
          exec_kind_out <= kind_now;
          exec_mant_out <= mant;
          exec_frac_out <= frac;
          exec_exp_out <= expo;
          exec_neg_out <= neg;
          exec_exp_neg_out <= eneg;
        end else if (pst != P_SKIP) begin
          if (leaf_now == 4'h0 || kind_now == D_BAD) begin
            cmd_error_out <= 1'b1;
          end else begin
            base <= node;
            if (leaf_now == `NODE_VOLT_AC && !query) begin
              pend_ac <= 1'b1;
              pa_kind <= kind_now;
              pa_mant <= mant;
              pa_int <= ip;
              pa_frac <= frac;
              pa_exp <= expo;
              pa_neg <= neg;
              pa_eneg <= eneg;
            end else if (leaf_now == `NODE_RANGE && !query) begin
              pend_rng <= 1'b1;
              pend_high <= (tok == `TOK_HIGH);
            end else begin
              exec_valid_out <= 1'b1;
              exec_common_out <= 1'b0;
              exec_node_out <= leaf_now;
              exec_query_out <= query;
              exec_kind_out <= kind_now;
              exec_mant_out <= mant;
              exec_frac_out <= frac;
              exec_exp_out <= expo;
              exec_neg_out <= neg;
              exec_exp_neg_out <= eneg;
              exec_bool_out <= (tok == `TOK_ON);
            end
          end
        end
      end
      if (is_end) begin
        base <= 4'h0;
        pst <= P_FLUSH_RNG;
        rx_ready_out <= 1'b0;
      end
    end
  end

  assign resp_accept = resp_valid_in && resp_ready_out;

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      resp_ready_out <= 1'b1;
      resp_busy <= 1'b0;
      resp_drop <= 1'b0;
      resp_cnt <= 4'h0;
      nl_pend <= 1'b0;
      tx_valid_out <= 1'b0;
      tx_byte_out <= 8'h00;
      tx_eoi_out <= 1'b0;
      query_error_out <= 1'b0;
    end else begin
      query_error_out <= 1'b0;
      if (tx_valid_out && tx_ready_in) begin
        tx_valid_out <= 1'b0;
        resp_ready_out <= !nl_pend;
      end else if (nl_pend && !tx_valid_out) begin
        tx_valid_out <= 1'b1;
        tx_byte_out <= `CH_NL;
        tx_eoi_out <= !serial_mode_in;
        nl_pend <= 1'b0;
      end
      if (resp_accept) begin
        resp_busy <= !resp_last_in;
        resp_cnt <= resp_last_in ? 4'h0 : (resp_cnt == 4'hF) ? 4'hF : resp_cnt + 4'h1;
        if (!resp_drop && !(resp_char_type_in && resp_cnt >= `CRD_MAX)) begin
          tx_valid_out <= 1'b1;
          tx_byte_out <= resp_byte_in;
          tx_eoi_out <= 1'b0;
          resp_ready_out <= 1'b0;
        end
        if (resp_last_in) begin
          resp_drop <= 1'b0;
          if (!resp_drop) begin
            nl_pend <= 1'b1;
            resp_ready_out <= 1'b0;
          end
        end
      end
      if (take_rx && resp_busy && !resp_drop && !(resp_accept && resp_last_in)) begin
        resp_drop <= 1'b1;
        query_error_out <= 1'b1;
      end
    end
  end

  always_comb begin
    esr_set = 8'h00;
    esr_set[`ESR_CME] = cmd_error_out;
    esr_set[`ESR_EXE] = range_error_out;
    esr_set[`ESR_QYE] = query_error_out;
    mav = resp_busy || tx_valid_out || nl_pend;
    esb = |(esr_out & ese_in);
    stb_sum = 8'h00;
    stb_sum[`STB_QUES] = ques_in;
    stb_sum[`STB_MAV] = mav;
    stb_sum[`STB_ESB] = esb;
    srq_cond = |(stb_sum & sre_in);
  end

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      esr_out <= 8'h00;
      srq_out <= 1'b0;
      poll_valid_out <= 1'b0;
      poll_byte_out <= 8'h00;
    end else begin
      // A new error in the clearing cycle still lands.
      esr_out <= (esr_out & ~{8{esr_clear_in}}) | esr_set;
      srq_out <= srq_cond;
      poll_valid_out <= poll_req_in;
      if (poll_req_in) begin
        poll_byte_out <= stb_sum | ({7'h00, srq_cond} << `STB_RQS);
      end
    end
  end

  always_comb begin
    key_edge = press_s2 && !press_s3;
    next_remote = remote_out;
    if (go_remote_in) begin
      next_remote = 1'b1;
    end else if (go_local_in || (key_edge && code_s2 == `KEY_ESCAPE)) begin
      next_remote = 1'b0;
    end
  end

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      press_s1 <= 1'b0;
      press_s2 <= 1'b0;
      press_s3 <= 1'b0;
      code_s1 <= 4'h0;
      code_s2 <= 4'h0;
      remote_out <= 1'b0;
      display_char_out <= `CH_SP;
      key_valid_out <= 1'b0;
      key_code_out <= 4'h0;
    end else begin
      press_s1 <= key_press_in;
      press_s2 <= press_s1;
      press_s3 <= press_s2;
      code_s1 <= key_code_in;
      code_s2 <= code_s1;
      remote_out <= next_remote;
      display_char_out <= next_remote ? `CH_R : `CH_SP;
      key_valid_out <= key_edge && !remote_out;
      key_code_out <= code_s2;
    end
  end
endmodule

// ===== tb/remote_command_parser_chk.sv
module remote_command_parser_chk (
  // Clock and reset
  input wire logic clk_in,
  input wire logic nrst_in,
  // Received bytes and responses
  input wire logic rx_valid_in,
  input wire logic [7:0] rx_byte_in,
  input wire logic rx_ready_out,
  input wire logic tx_valid_out,
  input wire logic [7:0] tx_byte_out,
  input wire logic tx_eoi_out,
  input wire logic tx_ready_in,
  input wire logic serial_mode_in,
  input wire logic query_error_out,
  // Status and panel
  input wire logic ques_in,
  input wire logic [7:0] sre_in,
  input wire logic srq_out,
  input wire logic poll_req_in,
  input wire logic poll_valid_out,
  input wire logic remote_out,
  input wire logic [7:0] display_char_out,
  input wire logic key_valid_out
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!nrst_in);
  srq_on_a: assert property ((ques_in && sre_in[3]) [*3] |-> srq_out)
    else $error("srq low with enabled condition");
  srq_off_a: assert property ((sre_in == 8'h00) [*3] |-> !srq_out)
    else $error("srq high with nothing enabled");
  poll_ans_a: assert property (poll_req_in |=> poll_valid_out)
    else $error("poll not answered");
  remote_mark_a: assert property (remote_out && $past(remote_out) |->
    display_char_out == 8'h52) else $error("remote marker missing");
  key_block_a: assert property (remote_out [*4] |-> !key_valid_out)
    else $error("key forwarded in remote");
  // A stalled sink must see the same byte until it takes it.
  tx_hold_a: assert property (tx_valid_out && !tx_ready_in |=> tx_valid_out &&
    $stable(tx_byte_out) && $stable(tx_eoi_out)) else $error("tx changed while stalled");
  tx_end_a: assert property (tx_valid_out && tx_byte_out == 8'h0A |->
    tx_eoi_out == !serial_mode_in) else $error("wrong end flag on newline");
  nl_flush_a: assert property (rx_valid_in && rx_ready_out && rx_byte_in == 8'h0A |=>
    !rx_ready_out [*2]) else $error("byte taken right after terminator");
  qerr_cause_a: assert property (query_error_out |->
    $past(rx_valid_in) && $past(rx_ready_out)) else $error("query error without byte");
endmodule

bind remote_command_parser remote_command_parser_chk chk (.*);

// ===== tb/rcp_host_model.sv
module rcp_host_model (
  // Clock
  input wire logic clk_in,
  // Response link
  input wire logic tx_valid_in,
  input wire logic [7:0] tx_byte_in,
  input wire logic tx_eoi_in,
  output logic tx_ready_out,
  // Pacing and capture
  input wire logic stall_in,
  output logic got_out,
  output logic [8:0] got_word_out
);
  timeunit 1ns;
  timeprecision 1ps;
  initial tx_ready_out = 1'b0;
  initial got_out = 1'b0;
  // Ready is registered so a stall can land anywhere inside a response.
  always @(posedge clk_in) begin
    got_out <= tx_valid_in && tx_ready_out;
    got_word_out <= {tx_eoi_in, tx_byte_in};
    tx_ready_out <= !stall_in;
  end
endmodule

// ===== tb/test_remote_command_parser.sv
`include "rcp_defs.svh"
module test_remote_command_parser import rcp_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_in = 0, nrst_in = 0, rx_valid_in = 0, rx_eoi_in = 0, resp_valid_in = 0;
  logic resp_last_in = 0, resp_char_type_in = 0, serial_mode_in = 0, ques_in = 0;
  logic esr_clear_in = 0, poll_req_in = 0, go_remote_in = 0, go_local_in = 0;
  logic key_press_in = 0, stall = 0, tx_ready_in, got;
  logic [7:0] rx_byte_in = 8'h00, resp_byte_in = 8'h00, ese_in = 8'h00, sre_in = 8'h00;
  logic [3:0] key_code_in = 4'h0, exec_node_out, key_code_out, exec_frac_out, kc;
  logic rx_ready_out, exec_valid_out, exec_common_out, exec_query_out, exec_neg_out;
  logic exec_exp_neg_out, exec_bool_out, cmd_error_out, range_error_out, resp_ready_out;
  logic tx_valid_out, tx_eoi_out, query_error_out, srq_out, poll_valid_out;
  logic key_valid_out, remote_out;
  logic [23:0] exec_code_out;
  data_kind_type exec_kind_out;
  logic [31:0] exec_mant_out, mant;
  logic [7:0] exec_exp_out, tx_byte_out, esr_out, poll_byte_out, display_char_out;
  logic [8:0] got_word;
  logic [8:0] got_q[$];
  logic [15:0] seq;
  logic [17:0] ex;
  logic [25:0] cc;
  int seed = 32'h34b1, checks = 0, error_cnt = 0, ce = 0, re = 0, qe = 0, kv = 0, r0, v;

  remote_command_parser DUT (.*);
  rcp_host_model host (.clk_in(clk_in), .tx_valid_in(tx_valid_out),
    .tx_byte_in(tx_byte_out), .tx_eoi_in(tx_eoi_out), .tx_ready_out(tx_ready_in),
    .stall_in(stall), .got_out(got), .got_word_out(got_word));

  always #12.5 clk_in = ~clk_in;

  always @(posedge clk_in) begin
    stall <= ($random(seed) % 2) != 0;
    if (exec_valid_out) begin
      seq <= {seq[11:0], exec_node_out};
      mant <= exec_mant_out;
      ex <= {exec_kind_out, exec_frac_out, exec_exp_out, exec_neg_out, exec_exp_neg_out,
        exec_bool_out};
      cc <= {exec_query_out, exec_common_out, exec_code_out};
    end
    ce <= ce + cmd_error_out;
    re <= re + range_error_out;
    qe <= qe + query_error_out;
    kv <= kv + key_valid_out;
    if (key_valid_out) kc <= key_code_out;
    if (got) got_q.push_back(got_word);
  end

  function automatic logic [17:0] pk(data_kind_type k, logic [3:0] f, logic [7:0] e,
    logic [2:0] s);
    return {k, f, e, s};
  endfunction

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("MISMATCH %s expected %0h seen %0h", what, exp, seen);
    end
  endtask

  task automatic summarize;
    $display("checks %0d error_cnt %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic send(input string s, input logic e);
    for (int i = 0; i < s.len(); i++) begin
      rx_valid_in <= 1'b1;
      rx_byte_in <= s[i];
      rx_eoi_in <= e && i == s.len() - 1;
      @(posedge clk_in);
      while (rx_ready_out !== 1'b1) @(posedge clk_in);
    end
    rx_valid_in <= 1'b0;
    rx_eoi_in <= 1'b0;
    rx_byte_in <= ~rx_byte_in;
    repeat (8) @(posedge clk_in);
  endtask

  task automatic run(input string s, input logic [15:0] n, input int c, input int r,
    input logic e = 1'b0);
    int c0, r1;
    c0 = ce;
    r1 = re;
    seq = 16'h0000;
    send(s, e);
    check("nodes", seq, n);
    check("cmd errors", ce - c0, c);
    check("range errors", re - r1, r);
  endtask

  task automatic resp(input string s, input logic ch, input logic l);
    for (int i = 0; i < s.len(); i++) begin
      resp_valid_in <= 1'b1;
      resp_byte_in <= s[i];
      resp_last_in <= l && i == s.len() - 1;
      resp_char_type_in <= ch;
      @(posedge clk_in);
      while (resp_ready_out !== 1'b1) @(posedge clk_in);
    end
    resp_valid_in <= 1'b0;
    resp_last_in <= 1'b0;
    resp_byte_in <= ~resp_byte_in;
    repeat (150) @(posedge clk_in);
  endtask

  task automatic resp_chk(input string s, input logic ch, input logic sm);
    int n;
    n = (ch && s.len() > `CRD_MAX) ? `CRD_MAX : s.len();
    serial_mode_in <= sm;
    got_q.delete();
    resp(s, ch, 1'b1);
    check("resp length", got_q.size(), n + 1);
    for (int i = 0; i < n; i++) check("resp byte", got_q[i], {1'b0, s[i]});
    check("resp end", got_q[n], {~sm, `CH_NL});
  endtask

  task automatic key(input logic [3:0] c);
    key_code_in <= c;
    key_press_in <= 1'b1;
    repeat (5) @(posedge clk_in);
    key_press_in <= 1'b0;
    repeat (5) @(posedge clk_in);
  endtask

  initial begin
    repeat (8) @(posedge clk_in);
    nrst_in <= 1'b1;
    @(posedge clk_in);
    check("local", remote_out, 1'b0);
    check("blank", display_char_out, `CH_SP);
    run("FREQ 5\n", 16'h0003, 0, 0);
    check("nr1", ex, pk(D_NR1, 4'h0, 8'h00, 3'h0));
    run("volt:dc -12.5\n", 16'h0008, 0, 0);
    check("nr2", ex, pk(D_NR2, 4'h1, 8'h00, 3'h4));
    check("mant", mant, 32'h0000007D);
    run("VOLTage:DC  1.5E-2\n", 16'h0008, 0, 0);
    check("nr3", ex, pk(D_NR3, 4'h1, 8'h02, 3'h2));
    run("VOLTA 1\n", 16'h0000, 1, 0);
    run("OUTP ON\n", 16'h0001, 0, 0);
    check("on", ex, pk(D_BOOL, 4'h0, 8'h00, 3'h1));
    run("OUTP:STAT OFF\n", 16'h0005, 0, 0);
    check("off", ex, pk(D_BOOL, 4'h0, 8'h00, 3'h0));
    send("*cls\n", 1'b0);
    check("common", cc, {2'b01, "CLS"});
    send("*idn?\n", 1'b0);
    check("common query", cc, {2'b11, "IDN"});
    run("FREQ?\n", 16'h0003, 0, 0);
    check("tree query", cc[25:24], 2'b10);
    run("FREQ 1.2.3\n", 16'h0000, 1, 0);
    run("OUTP:PROT;STAT ON\n", 16'h0045, 0, 0);
    run("VOLT:DC 1;FREQ 2\n", 16'h0008, 1, 0);
    run("VOLT:DC 1;:FREQ 2\n", 16'h0083, 0, 0);
    run("FREQ 7", 16'h0003, 0, 0, 1'b1);
    run("FREQ 8\n", 16'h0003, 0, 0, 1'b1);
    r0 = re;
    send("VOLT:AC 200\n", 1'b0);
    check("lone coupled", re - r0, 1);
    run("VOLT:AC 200;:VOLT:RANG HIGH;:FREQ 5\n", 16'h0397, 0, 0);
    for (int i = 0; i < 16; i++) begin
      v = {$random(seed)} % 100000;
      run($sformatf("FREQ %0d\n", v), 16'h0003, 0, 0);
      check("random mant", mant, v);
    end
    resp_chk("ABCDEFGHIJKLMNO", 1'b1, 1'b0);
    resp_chk("ABCDEFGHIJKLMNO", 1'b0, 1'b1);
    r0 = qe;
    resp("AB", 1'b0, 1'b0);
    send("FREQ 1\n", 1'b0);
    resp("C", 1'b0, 1'b1);
    check("query error", qe != r0, 1'b1);
    check("qye", esr_out[`ESR_QYE], 1'b1);
    ques_in <= 1'b1;
    sre_in <= 8'h08;
    repeat (4) @(posedge clk_in);
    check("srq ques", srq_out, 1'b1);
    poll_req_in <= 1'b1;
    @(posedge clk_in);
    poll_req_in <= 1'b0;
    @(posedge clk_in);
    check("poll valid", poll_valid_out, 1'b1);
    check("poll byte", poll_byte_out & 8'h48, 8'h48);
    ques_in <= 1'b0;
    ese_in <= 8'h20;
    sre_in <= 8'h20;
    repeat (4) @(posedge clk_in);
    check("srq esb", srq_out, 1'b1);
    esr_clear_in <= 1'b1;
    @(posedge clk_in);
    esr_clear_in <= 1'b0;
    repeat (3) @(posedge clk_in);
    check("srq cleared", srq_out, 1'b0);
    go_remote_in <= 1'b1;
    @(posedge clk_in);
    go_remote_in <= 1'b0;
    repeat (2) @(posedge clk_in);
    check("marker", display_char_out, `CH_R);
    r0 = kv;
    key(4'h3);
    key(`KEY_ESCAPE);
    check("keys blocked", kv - r0, 0);
    check("back local", remote_out, 1'b0);
    key(4'h5);
    check("key local", kc, 4'h5);
    summarize();
  end

  // More than twenty times the expected length of the whole run.
  initial begin
    #(25 * 40000);
    error_cnt++;
    summarize();
  end
endmodule
